/* rtl/rtf_pkg.sv */
// Constants shared by the retransmit FIFO block.
// Assumes one 250 MHz clock and an AHB-Lite register port.
`default_nettype none

package rtf_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int RT_SETUP_NS   = 12;
   localparam int RT_SETUP_CYC  = (RT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT_CNT_W      = 4;

   // ------------------------------------------------------------
   // Register map (byte addresses, low eight address bits)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STAT_ADDR = 8'h04;
   localparam logic [7:0] OFFS_ADDR = 8'h08;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Control fields, copied into the active modes at master reset
   localparam int         CTRL_FALL_THROUGH_MODE = 0;
   localparam int         CTRL_RLAT = 1;
   localparam int         CTRL_PFM  = 2;
   localparam int         CTRL_X9   = 3;
   localparam int         CTRL_W    = 4;
   localparam logic [3:0] CTRL_RST  = 4'h6;

   // Status: flags in bits 10..0, stored word count from bit 16
   localparam int ST_CNT_LSB  = 16;
   // Offsets: almost-empty in low half, almost-full from bit 16
   localparam int OFFS_AF_LSB = 16;

   // ------------------------------------------------------------
   // Offsets and byte lane
   // ------------------------------------------------------------
   localparam int          BYTE_W = 9;
   localparam logic [15:0] AE_DEF = 16'h007F;
   localparam logic [15:0] AF_DEF = 16'h007F;

   // Retransmit setup sequencer
   typedef enum {RT_IDLE, RT_SETUP} rtf_rt_e;

endpackage

`default_nettype wire

/* rtl/rtf_retransmit_fifo.sv */
// Retransmit FIFO with programmable almost flags and AHB-Lite control.
// Assumes writer, reader and bus master all run on the one clock.
`default_nettype none

module rtf_retransmit_fifo
   import rtf_pkg::*;
#(
   parameter int                DEPTH      = 8192,
   parameter int                AW         = 13,
   parameter int                DW         = 18,
   parameter int                OFF_W      = 13,
   parameter logic [OFF_W-1:0]  AE_DEFAULT = OFF_W'(AE_DEF),
   parameter logic [OFF_W-1:0]  AF_DEFAULT = OFF_W'(AF_DEF)
) (
   input  wire logic            clock,
   input  wire logic            rstn,
   input  wire logic            ce,
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic [31:0]          hrdata,
   input  wire logic            master_reset_n,
   input  wire logic            write_enable_n,
   input  wire logic [DW-1:0]   data_in,
   input  wire logic            read_enable_n,
   input  wire logic            retransmit_request_n,
   input  wire logic            offset_access_select_n,
   input  wire logic            output_enable_n,
   output logic [DW-1:0]        data_out,
   output logic                 data_out_en_n,
   output logic                 empty_flag_n,
   output logic                 full_flag_n,
   output logic                 output_ready_n,
   output logic                 input_ready_n,
   output logic                 almost_empty_flag_n,
   output logic                 almost_full_flag_n
);

   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_P   = (AW+1)'(1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic                fall_through_mode_reg, rlat_reg, pfm_reg, x9_reg;
   logic [CTRL_W-1:0]   ctrl_reg;
   logic [DW-1:0]       mem [DEPTH];
   logic [AW:0]         wptr_reg, rptr_reg, cnt_reg;
   logic [AW:0]         rptr_next, cnt_next;
   logic [DW-1:0]       dout_reg;
   logic                valid_reg, vld_next, pend_reg, ld;
   logic [AW-1:0]       ld_addr;
   rtf_rt_e             st_reg, st_next;
   logic [RT_CNT_W-1:0] rtc_reg;
   logic [OFF_W-1:0]    ae_off_reg, af_off_reg;
   logic [1:0]          lidx_reg, ridx_reg;
   logic                ef_reg, ff_reg, or_reg, ir_reg, ae_reg, af_reg;
   logic                ap_reg, apw_reg;
   logic [7:0]          apa_reg;
   logic [31:0]         hrdata_reg;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Almost-full and almost-empty hits for a word count
   function automatic logic [1:0] near_edge(input logic [AW:0] n,
                                            input logic [AW:0] d,
                                            input logic [AW:0] ae,
                                            input logic [AW:0] af);
      return {n >= d - af, n <= ae};
   endfunction

   // Load one part of an offset from the data bus
   function automatic logic [OFF_W-1:0] off_put(input logic [OFF_W-1:0] old,
                                                input logic [DW-1:0]    d,
                                                input logic             hi,
                                                input logic             x9);
      logic [OFF_W-1:0] r;
      r = old;
      if (!x9) begin
         r = {1'b0, d[OFF_W-2:0]};
      end else if (hi) begin
         // Masks and shifts keep narrow offsets legal; excess bits drop off
         r = (old & OFF_W'((1 << BYTE_W) - 1)) | OFF_W'({d, {BYTE_W{1'b0}}});
      end else begin
         r = (old & ~OFF_W'((1 << BYTE_W) - 1)) | OFF_W'(d[BYTE_W-1:0]);
      end
      return r;
   endfunction

   // Present one part of an offset on the data bus
   function automatic logic [DW-1:0] off_get(input logic [OFF_W-1:0] off,
                                             input logic             hi,
                                             input logic             x9);
      logic [DW-1:0] r;
      r = DW'(off);
      if (x9 && hi) begin
         r = DW'(off >> BYTE_W);
      end else if (x9) begin
         r = DW'(off & OFF_W'((1 << BYTE_W) - 1));
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   wire logic          in_setup   = (st_reg == RT_SETUP);
   wire logic          setup_done = in_setup && rtc_reg == RT_CNT_W'(RT_SETUP_CYC - 1);
   wire logic          off_sel    = !offset_access_select_n;
   wire logic          nonempty   = (cnt_reg != '0);
   wire logic          full_c     = (cnt_reg == DEPTH_C);
   // Normal latency needs both enables high; zero latency ignores read
   wire logic          rt_go      = !retransmit_request_n && !in_setup && write_enable_n
                                    && (read_enable_n || !rlat_reg);
   wire logic          busy       = in_setup || rt_go;
   wire logic          wr_ok      = !write_enable_n && !off_sel && !full_c && !busy;
   wire logic          rd_std     = !fall_through_mode_reg && !read_enable_n && !off_sel && nonempty && !busy;
   wire logic          pop        = fall_through_mode_reg && !read_enable_n && !off_sel && valid_reg && !busy;
   // Fall-through refill: direct on a pop, else after the staging cycle
   wire logic          fill       = fall_through_mode_reg && nonempty && !busy
                                    && (pop || (!valid_reg && pend_reg));
   wire logic          mem_rd     = rd_std || fill;
   wire logic          off_ld     = off_sel && !write_enable_n;
   wire logic          off_rd     = off_sel && !read_enable_n;
   wire logic [1:0]    idx_step   = x9_reg ? 2'h1 : 2'h2;
   wire logic [DW-1:0] first_word = mem[0];

   // Almost-flag thresholds, with the output word counted in fall-through
   wire logic [AW:0]   ae_ext     = (AW+1)'(ae_off_reg);
   wire logic [AW:0]   af_ext     = (AW+1)'(af_off_reg);
   wire logic [AW:0]   depth_eff  = DEPTH_C + (AW+1)'(fall_through_mode_reg);
   wire logic [AW:0]   total_now  = cnt_reg + (AW+1)'(fall_through_mode_reg && valid_reg);
   wire logic [AW:0]   total_next = cnt_next + (AW+1)'(fall_through_mode_reg && vld_next);
   wire logic [1:0]    near_now   = near_edge(total_now, depth_eff, ae_ext, af_ext);
   wire logic [1:0]    near_nxt   = near_edge(total_next, depth_eff, ae_ext, af_ext);
   // Synchronous timing trails the count by one edge
   wire logic [1:0]    near_sel   = pfm_reg ? near_now : near_nxt;

   // ------------------------------------------------------------
   // Read pointer, count and output word
   // ------------------------------------------------------------
   // Next read side values, retransmit taking precedence
   always_comb begin
      rptr_next = rptr_reg;
      cnt_next  = cnt_reg;
      vld_next  = valid_reg;
      ld        = 1'b0;
      ld_addr   = rptr_reg[AW-1:0];
      if (wr_ok) begin
         cnt_next = cnt_next + 1'b1;
      end
      if (mem_rd) begin
         ld        = 1'b1;
         rptr_next = rptr_reg + 1'b1;
         cnt_next  = cnt_next - 1'b1;
         vld_next  = 1'b1;
      end else if (pop) begin
         vld_next = 1'b0;
      end
      if (rt_go && !rlat_reg) begin
         ld        = 1'b1;
         ld_addr   = '0;
         rptr_next = ONE_P;
         cnt_next  = wptr_reg - 1'b1;
         vld_next  = 1'b1;
      end else if (rt_go) begin
         rptr_next = '0;
         cnt_next  = wptr_reg;
         vld_next  = 1'b0;
      end else if (setup_done && fall_through_mode_reg) begin
         ld        = 1'b1;
         ld_addr   = '0;
         rptr_next = ONE_P;
         cnt_next  = wptr_reg - 1'b1;
         vld_next  = 1'b1;
      end
   end

   // Retransmit setup sequencer
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         RT_IDLE:  if (rt_go && rlat_reg) st_next = RT_SETUP;
         RT_SETUP: if (setup_done) st_next = RT_IDLE;
         default:  st_next = RT_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Clocked state
   // ------------------------------------------------------------
   // Active modes caught while master reset is held
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {x9_reg, pfm_reg, rlat_reg, fall_through_mode_reg} <= CTRL_RST;
      end else if (ce && !master_reset_n) begin
         fall_through_mode_reg <= ctrl_reg[CTRL_FALL_THROUGH_MODE];
         rlat_reg <= ctrl_reg[CTRL_RLAT];
         pfm_reg  <= ctrl_reg[CTRL_PFM];
         x9_reg   <= ctrl_reg[CTRL_X9];
      end
   end

   // Pointers, count and retransmit sequencer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         cnt_reg   <= '0;
         valid_reg <= 1'b0;
         pend_reg  <= 1'b0;
         st_reg    <= RT_IDLE;
         rtc_reg   <= '0;
      end else if (ce && !master_reset_n) begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         cnt_reg   <= '0;
         valid_reg <= 1'b0;
         pend_reg  <= 1'b0;
         st_reg    <= RT_IDLE;
         rtc_reg   <= '0;
      end else if (ce) begin
         wptr_reg  <= wptr_reg + (AW+1)'(wr_ok);
         rptr_reg  <= rptr_next;
         cnt_reg   <= cnt_next;
         valid_reg <= vld_next;
         pend_reg  <= fall_through_mode_reg && nonempty && !valid_reg && !busy;
         st_reg    <= st_next;
         rtc_reg   <= in_setup ? rtc_reg + 1'b1 : '0;
      end
   end

   // Storage array; written only from the data path
   always_ff @(posedge clock) begin
      if (ce && master_reset_n && wr_ok) begin
         mem[wptr_reg[AW-1:0]] <= data_in;
      end
   end

   // Offset registers, loaded and read in parts through the data ports
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         // Reset width follows the reset bus mode
         ae_off_reg <= CTRL_RST[CTRL_X9] ? AE_DEFAULT : {1'b0, AE_DEFAULT[OFF_W-2:0]};
         af_off_reg <= CTRL_RST[CTRL_X9] ? AF_DEFAULT : {1'b0, AF_DEFAULT[OFF_W-2:0]};
         lidx_reg   <= '0;
         ridx_reg   <= '0;
      end else if (ce && !master_reset_n) begin
         ae_off_reg <= x9_reg ? AE_DEFAULT : {1'b0, AE_DEFAULT[OFF_W-2:0]};
         af_off_reg <= x9_reg ? AF_DEFAULT : {1'b0, AF_DEFAULT[OFF_W-2:0]};
         lidx_reg   <= '0;
         ridx_reg   <= '0;
      end else if (ce) begin
         if (off_ld && !lidx_reg[1]) begin
            ae_off_reg <= off_put(ae_off_reg, data_in, lidx_reg[0], x9_reg);
         end
         if (off_ld && lidx_reg[1]) begin
            af_off_reg <= off_put(af_off_reg, data_in, lidx_reg[0], x9_reg);
         end
         if (off_ld) begin
            lidx_reg <= lidx_reg + idx_step;
         end
         if (off_rd) begin
            ridx_reg <= ridx_reg + idx_step;
         end
      end
   end

   // Output word: FIFO data or an offset part
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dout_reg <= '0;
      end else if (ce && master_reset_n) begin
         if (ld) begin
            dout_reg <= mem[ld_addr];
         end else if (off_rd) begin
            dout_reg <= off_get(ridx_reg[1] ? af_off_reg : ae_off_reg,
                                ridx_reg[0], x9_reg);
         end
      end
   end

   // Status flags, all active low, updated from next-state values; almost flags use the current count when pfm_reg is set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {ef_reg, ff_reg, or_reg, ir_reg, ae_reg, af_reg} <= 6'h19;
      end else if (ce && !master_reset_n) begin
         {ef_reg, ff_reg, or_reg, ir_reg, ae_reg, af_reg} <= 6'h19;
      end else if (ce) begin
         ef_reg <= fall_through_mode_reg || (st_next == RT_IDLE && cnt_next != '0);
         ff_reg <= fall_through_mode_reg || cnt_next != DEPTH_C;
         or_reg <= !fall_through_mode_reg || !vld_next;
         ir_reg <= fall_through_mode_reg && cnt_next == DEPTH_C;
         ae_reg <= !near_sel[0];
         af_reg <= !near_sel[1];
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   wire logic        take      = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
   wire logic [31:0] stat_word = (32'(cnt_reg) << ST_CNT_LSB)
                                 | 32'({x9_reg, pfm_reg, rlat_reg, fall_through_mode_reg, in_setup,
                                        ir_reg, or_reg, af_reg, ae_reg, ff_reg, ef_reg});
   wire logic [31:0] offs_word = (32'(af_off_reg) << OFFS_AF_LSB) | 32'(ae_off_reg);
   wire logic [31:0] rd_word   = (haddr[7:0] == CTRL_ADDR) ? 32'(ctrl_reg)
                               : (haddr[7:0] == STAT_ADDR) ? stat_word
                               : (haddr[7:0] == OFFS_ADDR) ? offs_word
                               : 32'h0000_0000;

   // Address phase capture and read data
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ap_reg     <= 1'b0;
         apw_reg    <= 1'b0;
         apa_reg    <= '0;
         hrdata_reg <= '0;
      end else if (ce) begin
         ap_reg  <= take;
         apw_reg <= hwrite;
         apa_reg <= haddr[7:0];
         if (take && !hwrite) begin
            hrdata_reg <= rd_word;
         end
      end
   end

   // Control register, written in the data phase
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= CTRL_RST;
      end else if (ce && ap_reg && apw_reg && apa_reg == CTRL_ADDR) begin
         ctrl_reg <= hwdata[CTRL_W-1:0];
      end
   end

   // Outputs
   assign hreadyout           = ce;
   assign hresp               = 1'b0;
   assign hrdata              = hrdata_reg;
   assign data_out            = dout_reg;
   assign data_out_en_n       = output_enable_n;
   assign empty_flag_n        = ef_reg;
   assign full_flag_n         = ff_reg;
   assign output_ready_n      = or_reg;
   assign input_ready_n       = ir_reg;
   assign almost_empty_flag_n = ae_reg;
   assign almost_full_flag_n  = af_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock iff ce); endclocking
   default disable iff (!rstn);

   sequence s_first_word;
      fall_through_mode_reg && master_reset_n && !valid_reg && !nonempty && !pend_reg && wr_ok;
   endsequence
   sequence s_quiet;
      (retransmit_request_n && master_reset_n) [*3];
   endsequence

   property p_std_setup;
      rt_go && rlat_reg && !fall_through_mode_reg && wptr_reg >= 2 && master_reset_n
         |=> (!ef_reg) [*3] ##1 ef_reg;
   endproperty
   a_std_setup: assert property (p_std_setup) else $error("setup end flag");

   property p_fall_through_mode_setup;
      setup_done && fall_through_mode_reg && master_reset_n |=> !or_reg && dout_reg == $past(first_word);
   endproperty
   a_fall_through_mode_setup: assert property (p_fall_through_mode_setup) else $error("setup end word");

   property p_mode_latch;
      !master_reset_n |=> rlat_reg == $past(ctrl_reg[CTRL_RLAT])
                          && fall_through_mode_reg == $past(ctrl_reg[CTRL_FALL_THROUGH_MODE]);
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");

   property p_zero_word;
      rt_go && !rlat_reg && master_reset_n |=> dout_reg == $past(first_word);
   endproperty
   a_zero_word: assert property (p_zero_word) else $error("zero latency word");

   property p_zero_std;
      rt_go && !rlat_reg && !fall_through_mode_reg && master_reset_n && wptr_reg >= 2 |=> ef_reg;
   endproperty
   a_zero_std: assert property (p_zero_std) else $error("zero latency empty");

   property p_zero_fall_through_mode;
      rt_go && !rlat_reg && fall_through_mode_reg && master_reset_n |=> !or_reg;
   endproperty
   a_zero_fall_through_mode: assert property (p_zero_fall_through_mode) else $error("zero latency ready");

   property p_depth;
      fall_through_mode_reg && ir_reg && !in_setup |-> total_now == DEPTH_C + 1;
   endproperty
   a_depth: assert property (p_depth) else $error("fall-through depth");

   property p_fall_latency;
      s_first_word ##0 s_quiet |-> or_reg ##1 !or_reg;
   endproperty
   a_fall_latency: assert property (p_fall_latency) else $error("first word latency");

   property p_ir_release;
      fall_through_mode_reg && ir_reg && pop && master_reset_n |=> !ir_reg;
   endproperty
   a_ir_release: assert property (p_ir_release) else $error("input ready stuck");

   property p_off_width;
      !x9_reg |-> !ae_off_reg[OFF_W-1] && !af_off_reg[OFF_W-1];
   endproperty
   a_off_width: assert property (p_off_width) else $error("offset too wide");

   property p_rt_keep;
      rt_go && master_reset_n |=> $stable(ae_off_reg) && $stable(af_off_reg)
                                 && rptr_reg == {{AW{1'b0}}, !rlat_reg};
   endproperty
   a_rt_keep: assert property (p_rt_keep) else $error("retransmit state");

endmodule

`default_nettype wire

/* verif/rtf_host.sv */
// Far-side host pins: tri-state read bus and writer fill count.
// Assumes the writer strobes on the device clock.
`default_nettype none
module rtf_host #(
   parameter int LIMIT = 14
) (
   input  wire logic        clock,
   input  wire logic        master_reset_n,
   input  wire logic        write_enable_n,
   input  wire logic [17:0] data_out,
   input  wire logic        data_out_en_n,
   output logic      [17:0] q_bus,
   output logic             over_fill
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_wr;
   // Bus floats unless the device drives it
   assign q_bus = data_out_en_n ? 'z : data_out;
   // Words written since master reset
   always_ff @(posedge clock) begin
      if (!master_reset_n) n_wr <= 0;
      else if (!write_enable_n) n_wr <= n_wr + 1;
   end
   // Fill before retransmit stays at depth minus two
   assign over_fill = (n_wr > LIMIT);
endmodule
`default_nettype wire

/* verif/rtf_retransmit_fifo_bench.sv */
// Bench: retransmit, fall-through and flag timing via pins and AHB.
// Assumes a 16-word device on one 250 MHz clock.
`default_nettype none
module rtf_retransmit_fifo_bench import rtf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 0, rstn = 0, hsel = 0, hwrite = 0, master_reset_n = 0;
   logic        write_enable_n = 1, read_enable_n = 1, retransmit_request_n = 1;
   logic        offset_access_select_n = 1;
   logic        output_enable_n = 0, hready, hreadyout, hresp, data_out_en_n;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = HSIZE_WORD;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [17:0] data_in = 0, data_out, q_bus;
   logic        empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
   logic        almost_empty_flag_n, almost_full_flag_n, over_fill;
   int          n_mismatch = 0, checked = 0;
   // ------------------------------------------------
   // Clock, device and host
   // ------------------------------------------------
   always #2 clock = ~clock;
   assign hready = hreadyout;
   rtf_retransmit_fifo #(.DEPTH(16), .AW(4), .DW(18), .OFF_W(5)) u_dut (
      .clock, .rstn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .master_reset_n,
      .write_enable_n, .data_in, .read_enable_n, .retransmit_request_n,
      .offset_access_select_n, .output_enable_n, .data_out,
      .data_out_en_n, .empty_flag_n, .full_flag_n, .output_ready_n,
      .input_ready_n, .almost_empty_flag_n, .almost_full_flag_n);
   rtf_host u_host (.clock, .master_reset_n, .write_enable_n, .data_out,
      .data_out_en_n, .q_bus, .over_fill);
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Single AHB transfer, waits for hready in both phases
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic mreset(input logic [31:0] ctrl);
      ahb(1, CTRL_ADDR, ctrl);
      @(posedge clock);
      master_reset_n <= 0;
      @(posedge clock);
      master_reset_n <= 1;
   endtask
   task automatic push(input int n, input int b);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         write_enable_n <= 0;
         data_in <= 18'h00A0 + 18'(b + i);
      end
      @(posedge clock);
      write_enable_n <= 1;
   endtask
   task automatic pop(input logic [17:0] exp);
      @(posedge clock);
      read_enable_n <= 0;
      @(posedge clock);
      read_enable_n <= 1;
      #1 cmp(data_out, exp);
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rt;
      @(posedge clock);
      retransmit_request_n <= 0;
      @(posedge clock);
      retransmit_request_n <= 1;
      #1;
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic s_std_normal;
      mreset(32'h0000_0006);
      push(3, 0);
      pop(18'h00A0);
      pop(18'h00A1);
      cmp(over_fill, 0);
      rt;
      cmp(empty_flag_n, 0);
      edges(2);
      cmp(empty_flag_n, 0);
      edges(1);
      cmp(empty_flag_n, 1);
      cmp(full_flag_n, 1);
      pop(18'h00A0);
      pop(18'h00A1);
   endtask
   task automatic s_std_zero;
      mreset(32'h0000_0004);
      push(3, 0);
      pop(18'h00A0);
      pop(18'h00A1);
      pop(18'h00A2);
      rt;
      cmp(data_out, 18'h00A0);
      edges(1);
      cmp(empty_flag_n, 1);
      pop(18'h00A1);
   endtask
   task automatic s_fall_through_mode;
      mreset(32'h0000_0007);
      push(1, 0);
      edges(1);
      cmp(output_ready_n, 1);
      edges(1);
      cmp(output_ready_n, 0);
      cmp(q_bus, 18'h00A0);
      @(posedge clock);
      output_enable_n <= 1;
      #1 cmp(q_bus, {14'h0, {18{1'bz}}});
      @(posedge clock);
      output_enable_n <= 0;
      push(2, 1);
      cmp(over_fill, 0);
      rt;
      cmp(output_ready_n, 1);
      cmp(input_ready_n, 0);
      edges(3);
      cmp(output_ready_n, 0);
      cmp(data_out, 18'h00A0);
   endtask
   // Offset load and read-back through the data ports, x18 parts
   task automatic s_offs;
      @(posedge clock);
      offset_access_select_n <= 0;
      write_enable_n <= 0;
      data_in <= 18'h0_0003;
      @(posedge clock);
      data_in <= 18'h0_0004;
      @(posedge clock);
      write_enable_n <= 1;
      read_enable_n <= 0;
      @(posedge clock);
      #1 cmp(data_out, 18'h0_0003);
      @(posedge clock);
      read_enable_n <= 1;
      offset_access_select_n <= 1;
      #1 cmp(data_out, 18'h0_0004);
      ahb(0, OFFS_ADDR, 0);
      cmp(rd, 32'h0004_0003);
      cmp(almost_empty_flag_n, 0);
      cmp(almost_full_flag_n, 1);
   endtask
   // Zero-latency retransmit in fall-through mode from an empty FIFO
   task automatic s_fall_through_mode_zero;
      mreset(32'h0000_0005);
      push(2, 0);
      pop(18'h00A1);
      pop(18'h00A1);
      cmp(output_ready_n, 1);
      rt;
      cmp(output_ready_n, 0);
      cmp(data_out, 18'h00A0);
   endtask
   task automatic s_fill;
      mreset(32'h0000_0003);
      push(16, 0);
      edges(1);
      cmp(input_ready_n, 0);
      push(1, 16);
      edges(1);
      cmp(input_ready_n, 1);
      cmp(almost_empty_flag_n, 1);
      cmp(almost_full_flag_n, 0);
      pop(18'h00A1);
      edges(1);
      cmp(input_ready_n, 0);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1;
      ahb(0, CTRL_ADDR, 0);
      cmp(rd, 32'h0000_0006);
      cmp(hresp, 1'b0);
      ahb(0, 8'h40, 0);
      cmp(rd, 32'h0000_0000);
      s_std_normal;
      s_std_zero;
      s_offs;
      s_fall_through_mode;
      s_fall_through_mode_zero;
      s_fill;
      final_report;
   end
   // Watchdog against a hang
   initial begin
      #20000;
      n_mismatch++;
      final_report;
   end
endmodule
`default_nettype wire
